// ### rtl/cspw_pkg.sv
// Shared constants and types of the chained serial wiper access block
package cspw_pkg;
	localparam logic [2:0] OP_NOP = 3'h0;
	localparam logic [2:0] OP_CTL_READ = 3'h1;
	localparam logic [2:0] OP_CTL_WRITE = 3'h3;
	localparam logic [2:0] OP_READ = 3'h4;
	localparam logic [2:0] OP_WRITE = 3'h6;
	localparam logic [2:0] READ_TAG = 3'h7;
	localparam logic [4:0] ADDR_WIPER_ZERO = 5'h00;
	localparam logic [4:0] ADDR_WIPER_ONE = 5'h01;
	localparam logic [4:0] ADDR_ACCESS_CONTROL = 5'h10;
	localparam logic [7:0] WIPER_RESET = 8'h40;
	localparam logic [7:0] ACCESS_CONTROL_RESET = 8'h40;
	localparam logic [7:0] ACCESS_CONTROL_MASK = 8'h42;
	localparam int SHUTDOWN_N_BIT = 6;
	localparam int OPEN_DRAIN_BIT = 1;
	localparam int FRAME_BITS = 16;
	localparam int COUNT_WIDTH = 4;
	localparam logic [3:0] COUNT_LAST = 4'hf;
	typedef struct packed {
		logic [2:0] op;
		logic [4:0] addr;
		logic [7:0] data;
	} cspw_frame_type;
endpackage

// ### rtl/cspw_top.sv
// Serial slave access logic of a dual wiper device with daisy chain support
`timescale 1ns/10ps
module cspw_top
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	output logic sdo_o,
	output logic sdo_oe,
	output logic [7:0] wiper_position_zero,
	output logic [7:0] wiper_position_one,
	output logic shutdown_n
);
	logic [1:0] sclk_sync_q;
	logic [1:0] cs_sync_q;
	logic [1:0] sdi_sync_q;
	logic sclk_prev_q;
	logic cs_prev_q;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;
	logic cs_fall;
	logic cs_active;
	cspw_pkg::cspw_frame_type shift_q;
	cspw_pkg::cspw_frame_type resp_d;
	logic [cspw_pkg::COUNT_WIDTH-1:0] count_q;
	logic full_q;
	logic frame_ok;
	logic [7:0] wiper0_q;
	logic [7:0] wiper1_q;
	logic [7:0] acr_q;
	logic pend_q;
	logic [4:0] pend_addr_q;
	logic sdo_bit_q;
	logic sdo_o_q;
	logic sdo_oe_q;
	logic [7:0] read_data;

	// Input synchronisers
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sclk_sync_q <= 2'h0;
			cs_sync_q <= 2'h3;
			sdi_sync_q <= 2'h0;
			sclk_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end
		else
		begin
			sclk_sync_q <= {sclk_sync_q[0], sclk};
			cs_sync_q <= {cs_sync_q[0], cs_n};
			sdi_sync_q <= {sdi_sync_q[0], sdi};
			sclk_prev_q <= sclk_sync_q[1];
			cs_prev_q <= cs_sync_q[1];
		end
	end

	assign cs_active = !cs_sync_q[1];
	assign sclk_rise = cs_active && sclk_sync_q[1] && !sclk_prev_q;
	assign sclk_fall = cs_active && !sclk_sync_q[1] && sclk_prev_q;
	assign cs_rise = cs_sync_q[1] && !cs_prev_q;
	assign cs_fall = !cs_sync_q[1] && cs_prev_q;
	assign frame_ok = full_q && (count_q == '0);

	// Read answer for the pending address
	always_comb
	begin
		case (pend_addr_q)
			cspw_pkg::ADDR_WIPER_ZERO: read_data = wiper0_q;
			cspw_pkg::ADDR_WIPER_ONE: read_data = wiper1_q;
			cspw_pkg::ADDR_ACCESS_CONTROL: read_data = acr_q;
			default: read_data = 8'h00;
		endcase
		resp_d.op = cspw_pkg::READ_TAG;
		resp_d.addr = pend_addr_q;
		resp_d.data = read_data;
	end

	// Two-byte shift path and bit count
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			shift_q <= '0;
			count_q <= '0;
			full_q <= 1'b0;
		end
		else if (cs_fall)
		begin
			count_q <= '0;
			full_q <= 1'b0;
			if (pend_q)
				shift_q <= resp_d;
		end
		else if (sclk_rise)
		begin
			shift_q <= {shift_q[cspw_pkg::FRAME_BITS-2:0], sdi_sync_q[1]};
			count_q <= count_q + 1'b1;
			if (count_q == cspw_pkg::COUNT_LAST)
				full_q <= 1'b1;
		end
	end

	// Serial output bit changes on falling edges
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			sdo_bit_q <= 1'b0;
		else if (cs_fall)
			sdo_bit_q <= pend_q ? resp_d[cspw_pkg::FRAME_BITS-1] : shift_q[cspw_pkg::FRAME_BITS-1];
		else if (sclk_fall)
			sdo_bit_q <= shift_q[cspw_pkg::FRAME_BITS-1];
	end

	// Pin drive: push-pull or open drain, released while deselected
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sdo_o_q <= 1'b0;
			sdo_oe_q <= 1'b0;
		end
		else
		begin
			sdo_o_q <= acr_q[cspw_pkg::OPEN_DRAIN_BIT] ? 1'b0 : sdo_bit_q;
			sdo_oe_q <= cs_active && !cs_fall
				&& (!acr_q[cspw_pkg::OPEN_DRAIN_BIT] || !sdo_bit_q);
		end
	end

	// Register writes on select rise
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wiper0_q <= cspw_pkg::WIPER_RESET;
			wiper1_q <= cspw_pkg::WIPER_RESET;
			acr_q <= cspw_pkg::ACCESS_CONTROL_RESET;
		end
		else if (cs_rise && frame_ok)
		begin
			if (shift_q.op == cspw_pkg::OP_WRITE)
			begin
				case (shift_q.addr)
					cspw_pkg::ADDR_WIPER_ZERO: wiper0_q <= shift_q.data;
					cspw_pkg::ADDR_WIPER_ONE: wiper1_q <= shift_q.data;
					cspw_pkg::ADDR_ACCESS_CONTROL:
						acr_q <= shift_q.data & cspw_pkg::ACCESS_CONTROL_MASK;
					default: ;
				endcase
			end
			else if (shift_q.op == cspw_pkg::OP_CTL_WRITE)
				acr_q <= shift_q.data & cspw_pkg::ACCESS_CONTROL_MASK;
		end
	end

	// Read request held until the next select phase
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pend_q <= 1'b0;
			pend_addr_q <= '0;
		end
		else if (cs_rise)
		begin
			pend_q <= frame_ok && (shift_q.op == cspw_pkg::OP_READ
				|| shift_q.op == cspw_pkg::OP_CTL_READ);
			pend_addr_q <= (shift_q.op == cspw_pkg::OP_CTL_READ)
				? cspw_pkg::ADDR_ACCESS_CONTROL : shift_q.addr;
		end
		else if (cs_fall)
			pend_q <= 1'b0;
	end

	assign sdo_o = sdo_o_q;
	assign sdo_oe = sdo_oe_q;
	assign wiper_position_zero = wiper0_q;
	assign wiper_position_one = wiper1_q;
	assign shutdown_n = acr_q[cspw_pkg::SHUTDOWN_N_BIT];

	// Sampled input history for the delay check
	logic [cspw_pkg::FRAME_BITS-1:0] hist_q;
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			hist_q <= '0;
		else if (sclk_rise)
			hist_q <= {hist_q[cspw_pkg::FRAME_BITS-2:0], sdi_sync_q[1]};
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	addr_zero_write_a: assert property (cs_rise && frame_ok && shift_q.op == cspw_pkg::OP_WRITE
		&& shift_q.addr == cspw_pkg::ADDR_WIPER_ZERO |=> wiper0_q == $past(shift_q.data))
		else $error("wiper zero write missed");
	wiper_readback_a: assert property (cs_fall && pend_q
		&& pend_addr_q == cspw_pkg::ADDR_WIPER_ONE |=> shift_q.data == wiper1_q)
		else $error("wiper one read back wrong");
	chain_delay_a: assert property (sclk_fall && full_q |=> sdo_bit_q == hist_q[15])
		else $error("chain delay not sixteen edges");
	write_at_rise_a: assert property ($changed(wiper0_q) || $changed(wiper1_q)
		|-> $past(cs_rise))
		else $error("wiper changed outside select rise");
	read_deferred_a: assert property (cs_rise && frame_ok && shift_q.op == cspw_pkg::OP_READ
		|=> pend_q && $stable(shift_q))
		else $error("read not deferred");
	read_tag_a: assert property (cs_fall && pend_q |=> shift_q.op == cspw_pkg::READ_TAG
		&& shift_q.addr == $past(pend_addr_q) ##0 sdo_bit_q)
		else $error("read tag wrong");
	nop_stable_a: assert property (cs_rise && shift_q.op == cspw_pkg::OP_NOP
		|=> $stable(wiper0_q) && $stable(wiper1_q) && $stable(acr_q) && !pend_q)
		else $error("nop changed state");
	out_on_fall_a: assert property ($changed(sdo_bit_q) |-> $past(sclk_fall || cs_fall))
		else $error("output changed off falling edge");
	reset_preset_a: assert property (!$past(reset_n) |-> wiper0_q == cspw_pkg::WIPER_RESET
		&& wiper1_q == cspw_pkg::WIPER_RESET)
		else $error("wiper preset wrong");
	deselect_release_a: assert property (!cs_active ##1 !cs_active |-> !sdo_oe_q)
		else $error("output driven while deselected");

	write_exec_c: cover property (cs_rise && frame_ok && shift_q.op == cspw_pkg::OP_WRITE);
	read_load_c: cover property (cs_fall && pend_q);
	open_drain_c: cover property (acr_q[cspw_pkg::OPEN_DRAIN_BIT] && sdo_oe_q);
endmodule

// ### tb/cspw_host.sv
// Host model that drives the serial link of the wiper block
`timescale 1ns/10ps
module cspw_host
(
	input wire logic ref_clk,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	output logic sclk,
	output logic cs_n,
	output logic sdi
);
	logic last_q = 1'b0;
	logic line;
	// Undriven line shows inverse of last value
	assign line = sdo_oe ? sdo_o : ~last_q;
	always @(posedge ref_clk)
	begin
		if (sdo_oe)
			last_q <= sdo_o;
	end
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic sel();
		cs_n <= 1'b0;
		wait_clk(2);
	endtask
	task automatic desel();
		wait_clk(6);
		cs_n <= 1'b1;
		wait_clk(8);
	endtask
	// One frame, MSB first, sampled on rises
	task automatic shift(input logic [15:0] tx, output logic [15:0] rx);
		for (int i = 15; i >= 0; i--)
		begin
			sdi <= tx[i];
			wait_clk(6);
			rx[i] = line;
			sclk <= 1'b1;
			wait_clk(6);
			sclk <= 1'b0;
		end
	endtask
endmodule

// ### tb/cspw_top_tb.sv
// Self-checking bench of the chained serial wiper block
`timescale 1ns/10ps
module cspw_top_tb;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic sclk, cs_n, sdi, sdo_o, sdo_oe, shutdown_n;
	logic [7:0] w0, w1;
	logic [15:0] rx;
	int miscompares = 0;
	int compares = 0;
	always #2 ref_clk = ~ref_clk;
	cspw_top cspw_top_inst (.ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk),
		.cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
		.wiper_position_zero(w0), .wiper_position_one(w1), .shutdown_n(shutdown_n));
	cspw_host cspw_host_inst (.ref_clk(ref_clk), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
		.sclk(sclk), .cs_n(cs_n), .sdi(sdi));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic cspw_pkg::cspw_frame_type frm(input logic [2:0] op,
		input logic [4:0] a, input logic [7:0] d);
		return {op, a, d};
	endfunction
	// One select phase of one or two frames
	task automatic phase(input logic [15:0] f0, input logic [15:0] f1, input int n);
		cspw_host_inst.sel();
		cspw_host_inst.shift(f0, rx);
		if (n > 1)
			cspw_host_inst.shift(f1, rx);
		cspw_host_inst.desel();
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		phase(frm(cspw_pkg::OP_WRITE, a, d), 16'h0, 1);
	endtask
	// Read request, then a no-operation phase to collect
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		phase(frm(cspw_pkg::OP_READ, a, 8'h00), 16'h0, 1);
		phase(frm(cspw_pkg::OP_NOP, 5'h00, 8'h00), 16'h0, 1);
		check(rx, {cspw_pkg::READ_TAG, a, exp});
	endtask
	task automatic give_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		cspw_host_inst.wait_clk(4);
		check({w0, w1}, 16'h4040);
		check({14'h0, sdo_oe, shutdown_n}, 16'h1);
		phase(frm(cspw_pkg::OP_WRITE, cspw_pkg::ADDR_WIPER_ZERO, 8'h99),
			frm(cspw_pkg::OP_WRITE, cspw_pkg::ADDR_WIPER_ONE, 8'h25), 2);
		check(rx, frm(cspw_pkg::OP_WRITE, cspw_pkg::ADDR_WIPER_ZERO, 8'h99));
		check({w0, w1}, 16'h4025);
		wr(cspw_pkg::ADDR_WIPER_ZERO, 8'h7f);
		check({w0, w1}, 16'h7f25);
		rd(cspw_pkg::ADDR_WIPER_ZERO, 8'h7f);
		rd(cspw_pkg::ADDR_WIPER_ONE, 8'h25);
		rd(cspw_pkg::ADDR_ACCESS_CONTROL, 8'h40);
		wr(cspw_pkg::ADDR_ACCESS_CONTROL, 8'h00);
		check({14'h0, sdo_oe, shutdown_n}, 16'h0);
		rd(cspw_pkg::ADDR_ACCESS_CONTROL, 8'h00);
		wr(cspw_pkg::ADDR_ACCESS_CONTROL, 8'h40);
		wr(5'h05, 8'h11);
		check({w0, w1}, 16'h7f25);
		check({15'h0, shutdown_n}, 16'h1);
		rd(5'h05, 8'h00);
		// Open drain output through the control write and read codes
		phase(frm(cspw_pkg::OP_CTL_WRITE, 5'h00, 8'h42), 16'h0, 1);
		check({15'h0, shutdown_n}, 16'h1);
		rd(cspw_pkg::ADDR_WIPER_ONE, 8'h25);
		phase(frm(cspw_pkg::OP_CTL_READ, 5'h00, 8'h00), 16'h0, 1);
		phase(frm(cspw_pkg::OP_NOP, 5'h00, 8'h00), 16'h0, 1);
		check(rx, {cspw_pkg::READ_TAG, cspw_pkg::ADDR_ACCESS_CONTROL, 8'h42});
		wr(cspw_pkg::ADDR_ACCESS_CONTROL, 8'h40);
		phase(frm(cspw_pkg::OP_NOP, cspw_pkg::ADDR_WIPER_ONE, 8'h33), 16'h0, 1);
		check({w0, w1}, 16'h7f25);
		// Reset in mid-run brings the presets back
		reset_n <= 1'b0;
		cspw_host_inst.wait_clk(3);
		reset_n <= 1'b1;
		cspw_host_inst.wait_clk(4);
		check({w0, w1}, 16'h4040);
		check({14'h0, sdo_oe, shutdown_n}, 16'h1);
		rd(cspw_pkg::ADDR_WIPER_ZERO, 8'h40);
		give_verdict();
	end
endmodule
